// ==== irc_consts.svh ====
`ifndef IRC_CONSTS_SVH
`define IRC_CONSTS_SVH
// register offsets
`define IRC_OFS_ACT 8'h30
`define IRC_OFS_BOOT_BASE_HI 8'h40
`define IRC_OFS_BOOT_BASE_LO 8'h41
`define IRC_OFS_BOOT_WIDTH 8'h42
`define IRC_OFS_BOOT_SIZE_HI 8'h43
`define IRC_OFS_BOOT_SIZE_LO 8'h44
`define IRC_OFS_RAM_BASE_HI 8'h48
`define IRC_OFS_RAM_BASE_LO 8'h49
`define IRC_OFS_RAM_WIDTH 8'h4a
`define IRC_OFS_RAM_SIZE_HI 8'h4b
`define IRC_OFS_RAM_SIZE_LO 8'h4c
`define IRC_OFS_IO_BASE_HI 8'h60
`define IRC_OFS_IO_BASE_LO 8'h61
`define IRC_OFS_IRQ_SEL 8'h70
`define IRC_OFS_IRQ_SENSE 8'h71
`define IRC_OFS_DMA_SEL 8'h74
// fixed bits that read back in the split fields
`define IRC_IO_HI_FIXED 8'h02
`define IRC_BOOT_HI_FIXED 8'h0c
`define IRC_RAM_HI_FIXED 8'h0c
`define IRC_SIZE_HI_FIXED 8'hfe
// reset values
`define IRC_RST_IRQ_SEL 4'h3
`define IRC_RST_DMA_SEL 3'h4
`define IRC_RST_NIBBLE 4'h0
`define IRC_RST_RAM_BASE 5'h00
// interrupt line codes
`define IRC_IRQ_CODE3 4'h3
`define IRC_IRQ_CODE4 4'h4
`define IRC_IRQ_CODE5 4'h5
`define IRC_IRQ_CODE9 4'h9
`define IRC_IRQ_CODE10 4'ha
`define IRC_IRQ_CODE11 4'hb
`define IRC_IRQ_CODE12 4'hd
`define IRC_IRQ_CODE15 4'he
// dma channel codes
`define IRC_DMA_CODE3 3'h3
`define IRC_DMA_CODE5 3'h5
`define IRC_DMA_CODE6 3'h6
`define IRC_DMA_CODE7 3'h7
`define IRC_DMA_NONE 3'h4
// address decode
`define IRC_IO_TOP 1'h1
`define IRC_BOOT_TOP 3'h6
`endif

// ==== irc_pkg.sv ====
package irc_pkg;
   typedef struct packed {
      logic [3:0] io_base;
      logic [2:0] dma_sel;
      logic [3:0] boot_base;
   } irc_ee_t;
   typedef struct packed {
      logic bus_master;
      logic shared_mem;
   } irc_mode_t;
   typedef enum logic {
      IRC_SENSE_EDGE,
      IRC_SENSE_LEVEL
   } irc_sense_t;
endpackage

// ==== irc_window.sv ====
`timescale 1ns/100ps
module irc_window import irc_pkg::*; #(
   parameter int W = 4
) (
   input wire logic [W-1:0] i_base,
   input wire logic [3:0] i_size,
   input wire logic [W-1:0] i_addr,
   output logic o_hit
);
   logic [W-1:0] keep;
   logic legal;
   always_comb
   begin
      keep = '1;
      keep[2:0] = i_size[2:0];
      // base must be aligned to the chosen size
      legal = ((i_base[2:0] & ~i_size[2:0]) == 3'h0);
      o_hit = i_size[3] && legal && (((i_base ^ i_addr) & keep) == '0);
   end
endmodule

// ==== irc_config.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "irc_consts.svh"
// Function
// RULE1: io window at SA[8:5], 200h-3E0h
// RULE2: loader fills io, dma, boot base
// RULE3: irq code picks one line, default 3
// RULE4: no irq drive until activated
// RULE5: type bit: 1 level, 0 edge
// RULE6: polarity reads as inverted type
// RULE7: dma code picks channel 3,5,6,7 or none
// RULE8: bus master dma gated by activate
// RULE9: boot base compared with SA[16:13]
// RULE10: boot base must align to size
// RULE11: boot size codes, top bit zero none
// RULE12: boot wide unless bus master
// RULE13: shared ram decodes SA[15:13]
// RULE14: board decodes SA17, SA16 for ram
// RULE15: ram fields ignored outside shared mode
// RULE16: ram wide bit answers as 16-bit
// RULE17: ram size codes, top bit zero none
// RULE18: bit0 of 30h activates resources
module irc_config import irc_pkg::*; (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_ee_load,
   input wire irc_ee_t i_ee,
   input wire irc_mode_t i_mode,
   input wire logic i_irq_req,
   input wire logic i_dma_req,
   input wire logic [19:0] i_sa,
   input wire logic i_io_cyc,
   input wire logic i_mem_cyc,
   output logic o_io_hit,
   output logic o_boot_hit,
   output logic o_boot_wide,
   output logic o_ram_hit,
   output logic o_ram_wide,
   output logic [7:0] o_irq_line,
   output logic [7:0] o_irq_oe,
   output logic [3:0] o_drq,
   output logic [3:0] o_drq_oe
);
   logic act_ff;
   logic [3:0] io_base_ff;
   logic [3:0] irq_sel_ff;
   irc_sense_t sense_ff;
   logic [2:0] dma_sel_ff;
   logic [3:0] boot_base_ff;
   logic boot_rom_wide_ff;
   logic [3:0] boot_rom_size_ff;
   logic [4:0] ram_base_ff;
   logic shared_ram_wide_ff;
   logic [3:0] shared_ram_size_ff;
   logic [7:0] nxt_rdata;
   logic [19:0] sa_meta_ff;
   logic [19:0] sa_ff;
   logic [1:0] cyc_meta_ff;
   logic [1:0] cyc_ff;
   logic interrupt_polarity;
   logic io_base_match;
   logic boot_rom_base_match;
   logic ram_match;
   logic [7:0] irq_pick;
   logic [3:0] dma_pick;
   logic wr_hit;

   assign interrupt_polarity = ~sense_ff; // see RULE6

   // pins cross in through two flops
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         sa_meta_ff <= 20'h00000;
         sa_ff <= 20'h00000;
         cyc_meta_ff <= 2'h0;
         cyc_ff <= 2'h0;
      end
      else
      begin
         sa_meta_ff <= i_sa;
         sa_ff <= sa_meta_ff;
         cyc_meta_ff <= {i_mem_cyc, i_io_cyc};
         cyc_ff <= cyc_meta_ff;
      end
   end

   assign wr_hit = i_wr;

   // loader and software share the fields; the loader wins a tie
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         io_base_ff <= `IRC_RST_NIBBLE;
         dma_sel_ff <= `IRC_RST_DMA_SEL;
         boot_base_ff <= `IRC_RST_NIBBLE;
      end
      else if (i_ee_load)
      begin
         io_base_ff <= i_ee.io_base; // see RULE2
         dma_sel_ff <= i_ee.dma_sel; // see RULE2
         boot_base_ff <= i_ee.boot_base; // see RULE2
      end
      else if (wr_hit)
      begin
         case (i_addr)
            `IRC_OFS_IO_BASE_HI: io_base_ff[3] <= i_wdata[0];
            `IRC_OFS_IO_BASE_LO: io_base_ff[2:0] <= i_wdata[7:5];
            `IRC_OFS_DMA_SEL: dma_sel_ff <= i_wdata[2:0];
            `IRC_OFS_BOOT_BASE_HI: boot_base_ff[3] <= i_wdata[0];
            `IRC_OFS_BOOT_BASE_LO: boot_base_ff[2:0] <= i_wdata[7:5];
            default: io_base_ff <= io_base_ff;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         act_ff <= 1'h0;
         irq_sel_ff <= `IRC_RST_IRQ_SEL; // see RULE3
         sense_ff <= IRC_SENSE_EDGE; // see RULE5
      end
      else if (wr_hit)
      begin
         case (i_addr)
            `IRC_OFS_ACT: act_ff <= i_wdata[0]; // see RULE18
            `IRC_OFS_IRQ_SEL: irq_sel_ff <= i_wdata[3:0];
            `IRC_OFS_IRQ_SENSE: sense_ff <= irc_sense_t'(i_wdata[0]);
            default: act_ff <= act_ff;
         endcase
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         boot_rom_wide_ff <= 1'h0;
         boot_rom_size_ff <= `IRC_RST_NIBBLE;
         ram_base_ff <= `IRC_RST_RAM_BASE;
         shared_ram_wide_ff <= 1'h0;
         shared_ram_size_ff <= `IRC_RST_NIBBLE;
      end
      else if (wr_hit)
      begin
         case (i_addr)
            `IRC_OFS_BOOT_WIDTH: boot_rom_wide_ff <= i_wdata[1];
            `IRC_OFS_BOOT_SIZE_HI: boot_rom_size_ff[3] <= i_wdata[0];
            `IRC_OFS_BOOT_SIZE_LO: boot_rom_size_ff[2:0] <= i_wdata[7:5];
            `IRC_OFS_RAM_BASE_HI: ram_base_ff[4:3] <= i_wdata[1:0];
            `IRC_OFS_RAM_BASE_LO: ram_base_ff[2:0] <= i_wdata[7:5];
            `IRC_OFS_RAM_WIDTH: shared_ram_wide_ff <= i_wdata[1];
            `IRC_OFS_RAM_SIZE_HI: shared_ram_size_ff[3] <= i_wdata[0];
            `IRC_OFS_RAM_SIZE_LO: shared_ram_size_ff[2:0] <= i_wdata[7:5];
            default: boot_rom_wide_ff <= boot_rom_wide_ff;
         endcase
      end
   end

   // read mux; fixed bits read as printed, unmapped reads zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      case (i_addr)
         `IRC_OFS_ACT: nxt_rdata = {7'h00, act_ff};
         `IRC_OFS_IO_BASE_HI: nxt_rdata = `IRC_IO_HI_FIXED | {7'h00, io_base_ff[3]};
         `IRC_OFS_IO_BASE_LO: nxt_rdata = {io_base_ff[2:0], 5'h00};
         `IRC_OFS_IRQ_SEL: nxt_rdata = {4'h0, irq_sel_ff};
         `IRC_OFS_IRQ_SENSE: nxt_rdata = {6'h00, interrupt_polarity, sense_ff}; // see RULE6
         `IRC_OFS_DMA_SEL: nxt_rdata = {5'h00, dma_sel_ff};
         `IRC_OFS_BOOT_BASE_HI: nxt_rdata = `IRC_BOOT_HI_FIXED | {7'h00, boot_base_ff[3]};
         `IRC_OFS_BOOT_BASE_LO: nxt_rdata = {boot_base_ff[2:0], 5'h00};
         `IRC_OFS_BOOT_WIDTH: nxt_rdata = {6'h00, boot_rom_wide_ff, 1'h0};
         `IRC_OFS_BOOT_SIZE_HI: nxt_rdata = `IRC_SIZE_HI_FIXED | {7'h00, boot_rom_size_ff[3]};
         `IRC_OFS_BOOT_SIZE_LO: nxt_rdata = {boot_rom_size_ff[2:0], 5'h00};
         `IRC_OFS_RAM_BASE_HI: nxt_rdata = `IRC_RAM_HI_FIXED | {6'h00, ram_base_ff[4:3]};
         `IRC_OFS_RAM_BASE_LO: nxt_rdata = {ram_base_ff[2:0], 5'h00};
         `IRC_OFS_RAM_WIDTH: nxt_rdata = {6'h00, shared_ram_wide_ff, 1'h0};
         `IRC_OFS_RAM_SIZE_HI: nxt_rdata = `IRC_SIZE_HI_FIXED | {7'h00, shared_ram_size_ff[3]};
         `IRC_OFS_RAM_SIZE_LO: nxt_rdata = {shared_ram_size_ff[2:0], 5'h00};
         default: nxt_rdata = 8'h00;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= nxt_rdata;
      else
         o_rdata <= 8'h00;
   end

   assign io_base_match = (sa_ff[9] == `IRC_IO_TOP) && (sa_ff[8:5] == io_base_ff); // see RULE1

   irc_window #(.W(4)) u_boot_win (
      .i_base(boot_base_ff),
      .i_size(boot_rom_size_ff),
      .i_addr(sa_ff[16:13]),
      .o_hit(boot_rom_base_match)
   ); // see RULE9 see RULE10 see RULE11

   // upper ram bits are the board's job, not compared here
   irc_window #(.W(3)) u_ram_win (
      .i_base(ram_base_ff[2:0]),
      .i_size(shared_ram_size_ff),
      .i_addr(sa_ff[15:13]),
      .o_hit(ram_match)
   ); // see RULE13 see RULE14 see RULE17

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_io_hit <= 1'h0;
         o_boot_hit <= 1'h0;
         o_boot_wide <= 1'h0;
         o_ram_hit <= 1'h0;
         o_ram_wide <= 1'h0;
      end
      else
      begin
         o_io_hit <= act_ff && cyc_ff[0] && io_base_match; // see RULE1
         o_boot_hit <= act_ff && cyc_ff[1] && boot_rom_base_match
            && (sa_ff[19:17] == `IRC_BOOT_TOP); // see RULE9
         o_boot_wide <= boot_rom_wide_ff && !i_mode.bus_master; // see RULE12
         o_ram_hit <= act_ff && cyc_ff[1] && ram_match && i_mode.shared_mem; // see RULE15
         o_ram_wide <= shared_ram_wide_ff && i_mode.shared_mem; // see RULE16
      end
   end

   // unknown codes drive no line at all
   always_comb
   begin
      irq_pick = 8'h00;
      case (irq_sel_ff) // see RULE3
         `IRC_IRQ_CODE3: irq_pick = 8'h01;
         `IRC_IRQ_CODE4: irq_pick = 8'h02;
         `IRC_IRQ_CODE5: irq_pick = 8'h04;
         `IRC_IRQ_CODE9: irq_pick = 8'h08;
         `IRC_IRQ_CODE10: irq_pick = 8'h10;
         `IRC_IRQ_CODE11: irq_pick = 8'h20;
         `IRC_IRQ_CODE12: irq_pick = 8'h40;
         `IRC_IRQ_CODE15: irq_pick = 8'h80;
         default: irq_pick = 8'h00;
      endcase
      dma_pick = 4'h0;
      case (dma_sel_ff) // see RULE7
         `IRC_DMA_CODE3: dma_pick = 4'h1;
         `IRC_DMA_CODE5: dma_pick = 4'h2;
         `IRC_DMA_CODE6: dma_pick = 4'h4;
         `IRC_DMA_CODE7: dma_pick = 4'h8;
         default: dma_pick = 4'h0;
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_irq_line <= 8'h00;
         o_irq_oe <= 8'h00;
      end
      else
      begin
         // level mode signals active low, edge mode active high
         o_irq_line <= irq_pick & {8{i_irq_req == interrupt_polarity}}; // see RULE5
         o_irq_oe <= irq_pick & {8{act_ff}}; // see RULE4
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_drq <= 4'h0;
         o_drq_oe <= 4'h0;
      end
      else
      begin
         o_drq <= dma_pick & {4{i_dma_req}};
         o_drq_oe <= dma_pick & {4{act_ff && i_mode.bus_master}}; // see RULE8
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   io_decode_a: assert property ( // see RULE1
      (act_ff && cyc_ff[0] && sa_ff[9] && sa_ff[8:5] == io_base_ff) |=> o_io_hit)
      else $error("io window not claimed");
   io_quiet_a: assert property ( // see RULE18
      !act_ff |=> !o_io_hit && !o_boot_hit && !o_ram_hit)
      else $error("decode live while inactive");
   ee_load_a: assert property ( // see RULE2
      i_ee_load |=> io_base_ff == $past(i_ee.io_base) && dma_sel_ff == $past(i_ee.dma_sel))
      else $error("loader value not taken");
   irq_default_a: assert property ( // see RULE3
      $fell(i_rst) |-> irq_sel_ff == `IRC_RST_IRQ_SEL && sense_ff == IRC_SENSE_EDGE)
      else $error("interrupt reset defaults wrong");
   irq_undriven_a: assert property ( // see RULE4
      !act_ff |=> o_irq_oe == 8'h00)
      else $error("irq driven while inactive");
   polarity_read_a: assert property ( // see RULE6
      (i_rd && i_addr == `IRC_OFS_IRQ_SENSE) |=> o_rdata[1] != o_rdata[0])
      else $error("polarity not complement of type");
   dma_gate_a: assert property ( // see RULE8
      (!act_ff || !i_mode.bus_master) |=> o_drq_oe == 4'h0)
      else $error("drq driven while not allowed");
   boot_narrow_a: assert property ( // see RULE12
      i_mode.bus_master |=> !o_boot_wide)
      else $error("boot wide in bus master mode");
   ram_ignored_a: assert property ( // see RULE15
      !i_mode.shared_mem |=> !o_ram_hit && !o_ram_wide)
      else $error("ram decode outside shared mode");
   boot_size_a: assert property ( // see RULE11
      o_boot_hit |-> $past(boot_rom_size_ff[3], 1))
      else $error("boot hit with no rom sized");
   boot_align_a: assert property ( // see RULE10
      (boot_base_ff[1] && !boot_rom_size_ff[1]) |=> !o_boot_hit)
      else $error("boot hit at misaligned base");
   ram_wide_a: assert property ( // see RULE16
      (shared_ram_wide_ff && i_mode.shared_mem) |=> o_ram_wide)
      else $error("ram wide not answered");
   dma_none_a: assert property ( // see RULE7
      (dma_sel_ff == `IRC_DMA_NONE) |=> o_drq_oe == 4'h0)
      else $error("drq driven with no channel");

   act_io_c: cover property (act_ff ##1 o_io_hit);
   boot_hit_c: cover property (o_boot_hit && o_boot_wide);
   irq_drive_c: cover property (o_irq_oe != 8'h00 ##1 o_irq_line != 8'h00);
   ram_hit_c: cover property (o_ram_hit);
endmodule

// ==== irc_isa_model.sv ====
`timescale 1ns/100ps
module irc_isa_model (
   input wire logic i_clock,
   output logic [19:0] o_sa,
   output logic o_io_cyc,
   output logic o_mem_cyc
);
   initial
   begin
      o_sa = 20'h00000;
      o_io_cyc = 1'b0;
      o_mem_cyc = 1'b0;
   end
   // board decode keeps sa17/16 at zero to match a ram base hi of zero
   task automatic start(input logic [19:0] addr, input logic io);
      @(posedge i_clock);
      o_sa <= addr;
      o_io_cyc <= io;
      o_mem_cyc <= ~io;
   endtask
   // released pins show the inverse, so a stale match cannot linger
   task automatic stop();
      @(posedge i_clock);
      o_sa <= ~o_sa;
      o_io_cyc <= 1'b0;
      o_mem_cyc <= 1'b0;
   endtask
endmodule

// ==== isa_resource_decode_config_tb_top.sv ====
`timescale 1ns/100ps
module isa_resource_decode_config_tb_top import irc_pkg::*;;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ee_load = 1'b0;
   irc_ee_t i_ee = '0;
   irc_mode_t i_mode = '0;
   logic i_irq_req = 1'b0;
   logic i_dma_req = 1'b0;
   logic [19:0] sa;
   logic io_cyc, mem_cyc;
   logic [7:0] o_rdata, o_irq_line, o_irq_oe;
   logic o_io_hit, o_boot_hit, o_boot_wide, o_ram_hit, o_ram_wide;
   logic [3:0] o_drq, o_drq_oe;
   int mismatches = 0;
   int check_count = 0;
   logic [3:0] irq_codes [8] = '{4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb, 4'hd, 4'he};
   logic [2:0] dma_codes [4] = '{3'h3, 3'h5, 3'h6, 3'h7};
   logic [7:0] rst_ofs [10] = '{8'h71, 8'h70, 8'h74, 8'h60, 8'h40, 8'h43, 8'h48, 8'h4b,
      8'h30, 8'h55};
   logic [7:0] rst_val [10] = '{8'h02, 8'h03, 8'h04, 8'h02, 8'h0c, 8'hfe, 8'h0c, 8'hfe,
      8'h00, 8'h00};

   initial
   begin
      forever #10 i_clock = ~i_clock;
   end

   irc_isa_model isa_u (.i_clock(i_clock), .o_sa(sa), .o_io_cyc(io_cyc),
      .o_mem_cyc(mem_cyc));
   irc_config dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ee_load(i_ee_load), .i_ee(i_ee),
      .i_mode(i_mode), .i_irq_req(i_irq_req), .i_dma_req(i_dma_req), .i_sa(sa),
      .i_io_cyc(io_cyc), .i_mem_cyc(mem_cyc), .o_io_hit(o_io_hit),
      .o_boot_hit(o_boot_hit), .o_boot_wide(o_boot_wide), .o_ram_hit(o_ram_hit),
      .o_ram_wide(o_ram_wide), .o_irq_line(o_irq_line), .o_irq_oe(o_irq_oe),
      .o_drq(o_drq), .o_drq_oe(o_drq_oe));

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk("rdata", o_rdata, exp);
   endtask
   // decode passes two sync flops and an output flop
   task automatic cyc(input logic [19:0] a, input logic io);
      isa_u.start(a, io);
      settle(3);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #200000;
      mismatches++;
      summarize();
   end

   initial
   begin
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int k = 0; k < 10; k++)
         rd(rst_ofs[k], rst_val[k]);
      @(posedge i_clock);
      i_ee_load <= 1'b1;
      i_ee <= '{io_base: 4'h8, dma_sel: 3'h5, boot_base: 4'h4};
      @(posedge i_clock);
      i_ee_load <= 1'b0;
      rd(8'h60, 8'h03);
      rd(8'h61, 8'h00);
      rd(8'h74, 8'h05);
      rd(8'h41, 8'h80);
      wr(8'h71, 8'hff);
      rd(8'h71, 8'h01);
      wr(8'h71, 8'h00);
      i_irq_req <= 1'b1;
      cyc(20'h00300, 1'b1);
      chk("idle_hit", {7'h00, o_io_hit}, 8'h00);
      chk("idle_irq_oe", o_irq_oe, 8'h00);
      wr(8'h30, 8'h01);
      settle(2);
      chk("io_hit", {7'h00, o_io_hit}, 8'h01);
      isa_u.stop();
      for (int b = 0; b < 16; b++)
      begin
         wr(8'h60, {7'h00, b[3]});
         wr(8'h61, {b[2:0], 5'h00});
         cyc(20'h00200 + 20'(b * 32), 1'b1);
         chk("io_hit", {7'h00, o_io_hit}, 8'h01);
         cyc(20'h00220 ^ 20'(b * 32), 1'b1);
         chk("io_miss", {7'h00, o_io_hit}, 8'h00);
      end
      isa_u.stop();
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h70, {4'h0, irq_codes[k]});
         settle(2);
         chk("irq_oe", o_irq_oe, 8'h01 << k);
         chk("irq_edge", o_irq_line, 8'h01 << k);
      end
      wr(8'h71, 8'h01);
      settle(2);
      chk("irq_level", o_irq_line, 8'h00);
      i_irq_req <= 1'b0;
      settle(2);
      chk("irq_level_idle", o_irq_line, 8'h80);
      i_mode <= '{bus_master: 1'b1, shared_mem: 1'b0};
      i_dma_req <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         wr(8'h74, {5'h00, dma_codes[k]});
         settle(2);
         chk("drq_oe", {4'h0, o_drq_oe}, 8'h01 << k);
         chk("drq", {4'h0, o_drq}, 8'h01 << k);
      end
      wr(8'h74, 8'h04);
      settle(2);
      chk("drq_none", {4'h0, o_drq_oe}, 8'h00);
      wr(8'h30, 8'h00);
      wr(8'h74, 8'h03);
      settle(2);
      chk("drq_inactive", {4'h0, o_drq_oe}, 8'h00);
      chk("irq_inactive", o_irq_oe, 8'h00);
      wr(8'h30, 8'h01);
      wr(8'h42, 8'h02);
      wr(8'h43, 8'h01);
      wr(8'h44, 8'he0);
      cyc(20'hc8000, 1'b0);
      chk("boot_hit", {7'h00, o_boot_hit}, 8'h01);
      chk("boot_wide_bm", {7'h00, o_boot_wide}, 8'h00);
      i_mode <= '{bus_master: 1'b0, shared_mem: 1'b1};
      settle(2);
      chk("boot_wide", {7'h00, o_boot_wide}, 8'h01);
      wr(8'h44, 8'h80);
      wr(8'h41, 8'h40);
      cyc(20'hc4000, 1'b0);
      chk("boot_misalign", {7'h00, o_boot_hit}, 8'h00);
      wr(8'h44, 8'he0);
      wr(8'h43, 8'h00);
      cyc(20'hc4000, 1'b0);
      chk("boot_none", {7'h00, o_boot_hit}, 8'h00);
      wr(8'h49, 8'h40);
      wr(8'h4a, 8'h02);
      wr(8'h4b, 8'h01);
      wr(8'h4c, 8'he0);
      cyc(20'h04000, 1'b0);
      chk("ram_hit", {7'h00, o_ram_hit}, 8'h01);
      chk("ram_wide", {7'h00, o_ram_wide}, 8'h01);
      wr(8'h4c, 8'h00);
      settle(1);
      chk("ram_64k_misalign", {7'h00, o_ram_hit}, 8'h00);
      wr(8'h4c, 8'he0);
      wr(8'h4b, 8'h00);
      settle(1);
      chk("ram_none", {7'h00, o_ram_hit}, 8'h00);
      wr(8'h4b, 8'h01);
      i_mode <= '{bus_master: 1'b1, shared_mem: 1'b0};
      settle(4);
      chk("ram_bm", {6'h00, o_ram_hit, o_ram_wide}, 8'h00);
      isa_u.stop();
      summarize();
   end
endmodule
